// file: sfmc_defines.vh
// constants for the switch forwarding mode configuration bank
// assumes byte offsets in configuration space and a 100 MHz core clock
`ifndef SFMC_DEFINES_VH
`define SFMC_DEFINES_VH

// register offsets
`define SFMC_OFF_MODE 8'hb4
`define SFMC_OFF_TEST 8'hb8

// mode field positions
`define SFMC_B_STORE_FWD 0
`define SFMC_B_THR_LO 1
`define SFMC_B_THR_HI 2
`define SFMC_B_ARB_HOLD 3
`define SFMC_B_CRED_ONE 4
`define SFMC_B_ORD_EGRESS 5
`define SFMC_B_ORD_CPL_TAG 6
`define SFMC_B_PM_LO 8
`define SFMC_B_PM_HI 13
`define SFMC_B_POL_DIS 14
`define SFMC_B_CMP_DIS 15
`define SFMC_B_DRV_LO 16
`define SFMC_B_DRV_HI 20

// reset values
`define SFMC_RST_THR 2'b01
`define SFMC_RST_PM 6'h00
`define SFMC_RST_DRIVE 5'b10111
`define SFMC_RST_RSV_A 5'b01101
`define SFMC_RST_RSV_B 5'b01000
`define SFMC_RST_TEST 32'h0000_4030

// credit release steps
`define SFMC_CRED_STEP_ONE 2'h1
`define SFMC_CRED_STEP_TWO 2'h2

`endif

// file: sfmc_link_partner.sv
// link partner credit pool feeding the release logic
// assumes the testbench adds credits and the device releases them
`timescale 1ns/1ps
module sfmc_link_partner (
    input wire clk_i, // core clock
    input wire rst_n_i, // async reset, active low
    input wire [7:0] add_i, // credits freed this cycle
    input wire fc_valid_i, // device release pulse
    input wire [1:0] fc_release_i, // credits released
    output reg [7:0] fc_avail_o // credits pending release
);
    // pool grows by freed credits, shrinks by what the device hands back
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fc_avail_o <= 8'h00;
        else
            fc_avail_o <= fc_avail_o + add_i - (fc_valid_i ? {6'h00, fc_release_i} : 8'h00);
    end
endmodule // sfmc_link_partner

// file: sfmc_rr_arbiter.v
// round-robin port arbiter with selectable hold policy
// assumes req, credit and advance are synchronous to clk_i
`timescale 1ns/1ps
module sfmc_rr_arbiter #(
    parameter N = 4
) (
    input wire clk_i, // core clock
    input wire rst_n_i, // async reset, active low
    input wire hold_mode_i, // stay on starved port
    input wire adv_i, // arbitration slot
    input wire [N-1:0] req_i, // port requests
    input wire [N-1:0] credit_ok_i, // egress credit sufficient
    output reg [N-1:0] grant_o // one-hot grant
);
    reg [N-1:0] nxt_grant;
    reg found;
    integer i;
    integer k;
    integer cur;

    // pick the next requesting port with credit after the current one
    always @*
    begin
        nxt_grant = grant_o;
        found = 1'b0;
        k = 0;
        cur = N - 1;
        for (i = 0; i < N; i = i + 1)
        begin
            if (grant_o[i])
                cur = i;
        end
        if (adv_i)
        begin
            if (hold_mode_i && |(grant_o & req_i & ~credit_ok_i))
                nxt_grant = grant_o;
            else
            begin
                nxt_grant = {N{1'b0}};
                for (i = 1; i <= N; i = i + 1)
                begin
                    k = (cur + i) % N;
                    if (!found && req_i[k] && credit_ok_i[k])
                    begin
                        nxt_grant[k] = 1'b1;
                        found = 1'b1;
                    end
                end
            end
        end
    end

    // grant register
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            grant_o <= {N{1'b0}};
        else
            grant_o <= nxt_grant;
    end
endmodule // sfmc_rr_arbiter

// file: sfmc_switch_mode.v
// switch forwarding mode register bank with forwarding, arbitration and credit control
// assumes configuration accesses, default loads and packet events are synchronous to clk_i
`timescale 1ns/1ps
`include "sfmc_defines.vh"
module sfmc_switch_mode (
    input wire clk_i, // core clock, 100 MHz
    input wire rst_n_i, // async reset, active low
    input wire cfg_wr_i, // config write strobe
    input wire cfg_rd_i, // config read strobe
    input wire cfg_dn_i, // 1 selects downstream port set
    input wire [7:0] cfg_addr_i, // config byte offset
    input wire [3:0] cfg_be_i, // config byte enables
    input wire [31:0] cfg_wdata_i, // config write data
    output reg [31:0] cfg_rdata_o, // config read data
    output reg cfg_rvalid_o, // read data valid pulse
    input wire ld_valid_i, // default load strobe
    input wire ld_eeprom_i, // 1 eeprom autoload, 0 smbus
    input wire ld_dn_i, // 1 selects downstream port set
    input wire [7:0] ld_addr_i, // load byte offset
    input wire [31:0] ld_data_i, // load data
    input wire [4:0] strap_low_drive_current_i, // low drive strap level
    output reg [4:0] up_drive_amp_o, // upstream drive amplitude
    output reg [4:0] dn_drive_amp_o, // downstream drive amplitude
    input wire rx_start_i, // packet receive starts
    input wire rx_done_i, // packet fully received
    input wire rx_good_i, // packet passed checks
    input wire [9:0] pkt_len_i, // packet length in cycles
    input wire slow_to_fast_i, // ingress slower than egress
    output reg tx_start_o, // start egress pulse
    input wire arb_adv_i, // arbitration slot
    input wire [3:0] port_req_i, // port requests
    input wire [3:0] port_credit_ok_i, // egress credit sufficient
    output wire [3:0] port_grant_o, // one-hot grant
    input wire fc_update_i, // credit update slot
    input wire [7:0] fc_avail_i, // credits ready for release
    output reg [1:0] fc_release_o, // credits released
    output reg fc_valid_o, // release pulse
    output reg ord_egress_o, // egress ordering enforced
    output reg ord_cpl_tag_o // completion tag ordering enforced
);
    // upstream mode fields
    reg store_fwd_ff;
    reg [1:0] thr_ff;
    reg arb_hold_ff;
    reg cred_one_ff;
    reg ord_eg_ff;
    reg ord_tag_ff;
    reg [5:0] up_pm_ff;
    reg up_pol_ff;
    reg up_cmp_ff;
    // downstream mode fields
    reg [5:0] dn_pm_ff;
    reg dn_pol_ff;
    reg dn_cmp_ff;
    // strap capture
    reg strap_done_ff;
    // forwarding state
    reg active_ff;
    reg sent_ff;
    reg [9:0] cnt_ff;
    reg [9:0] start_pt_ff;

    wire up_mode_wr;
    wire dn_mode_wr;
    wire up_mode_ld;
    wire dn_mode_ld;
    wire [9:0] half_len;
    wire [9:0] ahead;
    wire [9:0] nxt_start_pt;
    wire [1:0] cred_step;
    wire [31:0] up_word;
    wire [31:0] dn_word;
    reg [31:0] nxt_rdata;

    // access decode
    assign up_mode_wr = cfg_wr_i && !cfg_dn_i && (cfg_addr_i == `SFMC_OFF_MODE);
    assign dn_mode_wr = cfg_wr_i && cfg_dn_i && (cfg_addr_i == `SFMC_OFF_MODE);
    assign up_mode_ld = ld_valid_i && !ld_dn_i && (ld_addr_i == `SFMC_OFF_MODE);
    assign dn_mode_ld = ld_valid_i && ld_dn_i && (ld_addr_i == `SFMC_OFF_MODE);

    // upstream mode register, loads take priority over software writes
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            store_fwd_ff <= 1'b0;
            thr_ff <= `SFMC_RST_THR;
            arb_hold_ff <= 1'b0;
            cred_one_ff <= 1'b0;
            ord_eg_ff <= 1'b0;
            ord_tag_ff <= 1'b0;
            up_pm_ff <= `SFMC_RST_PM;
            up_pol_ff <= 1'b0;
            up_cmp_ff <= 1'b0;
        end
        else if (up_mode_ld)
        begin
            store_fwd_ff <= ld_data_i[`SFMC_B_STORE_FWD];
            thr_ff <= ld_data_i[`SFMC_B_THR_HI:`SFMC_B_THR_LO];
            arb_hold_ff <= ld_data_i[`SFMC_B_ARB_HOLD];
            cred_one_ff <= ld_data_i[`SFMC_B_CRED_ONE];
            ord_eg_ff <= ld_data_i[`SFMC_B_ORD_EGRESS];
            ord_tag_ff <= ld_data_i[`SFMC_B_ORD_CPL_TAG];
            up_pm_ff <= ld_data_i[`SFMC_B_PM_HI:`SFMC_B_PM_LO];
            up_pol_ff <= ld_data_i[`SFMC_B_POL_DIS];
            up_cmp_ff <= ld_data_i[`SFMC_B_CMP_DIS];
        end
        else if (up_mode_wr)
        begin
            if (cfg_be_i[0])
            begin
                store_fwd_ff <= cfg_wdata_i[`SFMC_B_STORE_FWD];
                thr_ff <= cfg_wdata_i[`SFMC_B_THR_HI:`SFMC_B_THR_LO];
                arb_hold_ff <= cfg_wdata_i[`SFMC_B_ARB_HOLD];
                cred_one_ff <= cfg_wdata_i[`SFMC_B_CRED_ONE];
                ord_eg_ff <= cfg_wdata_i[`SFMC_B_ORD_EGRESS];
                ord_tag_ff <= cfg_wdata_i[`SFMC_B_ORD_CPL_TAG];
            end
            if (cfg_be_i[1])
                up_pm_ff <= cfg_wdata_i[`SFMC_B_PM_HI:`SFMC_B_PM_LO];
        end
    end

    // downstream mode register
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dn_pm_ff <= `SFMC_RST_PM;
            dn_pol_ff <= 1'b0;
            dn_cmp_ff <= 1'b0;
        end
        else if (dn_mode_ld)
        begin
            dn_pm_ff <= ld_data_i[`SFMC_B_PM_HI:`SFMC_B_PM_LO];
            dn_pol_ff <= ld_data_i[`SFMC_B_POL_DIS];
            dn_cmp_ff <= ld_data_i[`SFMC_B_CMP_DIS];
        end
        else if (dn_mode_wr && cfg_be_i[1])
        begin
            dn_pm_ff <= cfg_wdata_i[`SFMC_B_PM_HI:`SFMC_B_PM_LO];
            dn_pol_ff <= cfg_wdata_i[`SFMC_B_POL_DIS];
            dn_cmp_ff <= cfg_wdata_i[`SFMC_B_CMP_DIS];
        end
    end

    // drive amplitude fields, read-only to software
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            up_drive_amp_o <= `SFMC_RST_DRIVE;
            dn_drive_amp_o <= `SFMC_RST_DRIVE;
            strap_done_ff <= 1'b0;
        end
        else
        begin
            strap_done_ff <= 1'b1;
            if (up_mode_ld && !ld_eeprom_i)
                up_drive_amp_o <= ld_data_i[`SFMC_B_DRV_HI:`SFMC_B_DRV_LO];
            if (dn_mode_ld)
                dn_drive_amp_o <= ld_data_i[`SFMC_B_DRV_HI:`SFMC_B_DRV_LO];
            else if (!strap_done_ff)
                dn_drive_amp_o <= strap_low_drive_current_i;
        end
    end

    // register words as seen by configuration reads
    assign up_word = {1'b0, `SFMC_RST_RSV_B, `SFMC_RST_RSV_A, up_drive_amp_o,
                      up_cmp_ff, up_pol_ff, up_pm_ff, 1'b0, ord_tag_ff, ord_eg_ff,
                      cred_one_ff, arb_hold_ff, thr_ff, store_fwd_ff};
    assign dn_word = {1'b0, `SFMC_RST_RSV_B, `SFMC_RST_RSV_A, dn_drive_amp_o,
                      dn_cmp_ff, dn_pol_ff, dn_pm_ff, 8'h00};

    // read mux, unmapped offsets read zero
    always @*
    begin
        case (cfg_addr_i)
            `SFMC_OFF_MODE: nxt_rdata = cfg_dn_i ? dn_word : up_word;
            `SFMC_OFF_TEST: nxt_rdata = `SFMC_RST_TEST;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read data register, one cycle after the strobe
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_rvalid_o <= 1'b0;
        end
        else
        begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i)
                cfg_rdata_o <= nxt_rdata;
        end
    end

    // cut-through start point: midpoint, pulled ahead only slow to fast
    assign half_len = {1'b0, pkt_len_i[9:1]};
    assign ahead = slow_to_fast_i ? {8'h00, thr_ff} : 10'h000;
    assign nxt_start_pt = (half_len > ahead) ? (half_len - ahead) : 10'h000;

    // forwarding sequencer
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            active_ff <= 1'b0;
            sent_ff <= 1'b0;
            cnt_ff <= 10'h000;
            start_pt_ff <= 10'h000;
            tx_start_o <= 1'b0;
        end
        else
        begin
            tx_start_o <= 1'b0;
            if (rx_start_i)
            begin
                active_ff <= 1'b1;
                sent_ff <= 1'b0;
                cnt_ff <= 10'h000;
                start_pt_ff <= nxt_start_pt;
            end
            else if (active_ff)
            begin
                cnt_ff <= cnt_ff + 10'h001;
                if (store_fwd_ff)
                begin
                    if (rx_done_i)
                    begin
                        active_ff <= 1'b0;
                        sent_ff <= rx_good_i;
                        tx_start_o <= rx_good_i;
                    end
                end
                else
                begin
                    if (!sent_ff && cnt_ff >= start_pt_ff)
                    begin
                        sent_ff <= 1'b1;
                        tx_start_o <= 1'b1;
                    end
                    if (rx_done_i)
                        active_ff <= 1'b0;
                end
            end
        end
    end

    // credit release per update slot
    assign cred_step = cred_one_ff ? `SFMC_CRED_STEP_ONE : `SFMC_CRED_STEP_TWO;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fc_release_o <= 2'h0;
            fc_valid_o <= 1'b0;
        end
        else
        begin
            fc_valid_o <= fc_update_i;
            if (fc_update_i)
            begin
                if (fc_avail_i >= {6'h00, cred_step})
                    fc_release_o <= cred_step;
                else
                    fc_release_o <= fc_avail_i[1:0];
            end
        end
    end

    // ordering enables towards the queue logic
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ord_egress_o <= 1'b0;
            ord_cpl_tag_o <= 1'b0;
        end
        else
        begin
            ord_egress_o <= ord_eg_ff;
            ord_cpl_tag_o <= ord_tag_ff;
        end
    end

    // port arbiter
    sfmc_rr_arbiter #(
        .N(4)
    ) u_arb (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .hold_mode_i(arb_hold_ff),
        .adv_i(arb_adv_i),
        .req_i(port_req_i),
        .credit_ok_i(port_credit_ok_i),
        .grant_o(port_grant_o)
    );
endmodule // sfmc_switch_mode

// file: sfmc_switch_mode_sva.sv
// port checker for the switch forwarding mode bank
// assumes it is bound to sfmc_switch_mode from the testbench top
`timescale 1ns/1ps
module sfmc_switch_mode_sva (
    input wire clk_i, // core clock
    input wire rst_n_i, // async reset, active low
    input wire cfg_rd_i, // config read strobe
    input wire cfg_wr_i, // config write strobe
    input wire ld_valid_i, // default load strobe
    input wire cfg_rvalid_o, // read data valid
    input wire arb_adv_i, // arbitration slot
    input wire [3:0] port_req_i, // port requests
    input wire [3:0] port_grant_o, // one-hot grant
    input wire fc_update_i, // credit update slot
    input wire [7:0] fc_avail_i, // credits pending
    input wire fc_valid_o, // release pulse
    input wire [1:0] fc_release_o, // credits released
    input wire tx_start_o, // egress start pulse
    input wire ord_egress_o, // egress ordering
    input wire ord_cpl_tag_o // completion tag ordering
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // read answered exactly one cycle later
    sequence s_read;
        cfg_rd_i ##1 cfg_rvalid_o;
    endsequence
    sequence s_quiet_cfg;
        (!cfg_wr_i && !ld_valid_i) [*2];
    endsequence
    a_read_answer: assert property (cfg_rd_i |-> s_read) else $error("read not answered");
    a_read_quiet: assert property (!cfg_rd_i |=> !cfg_rvalid_o) else $error("spurious read valid");
    a_grant_onehot: assert property ($onehot0(port_grant_o)) else $error("grant not one-hot");
    a_grant_hold: assert property (!arb_adv_i |=> $stable(port_grant_o)) else $error("grant moved");
    a_grant_request: assert property (arb_adv_i |=> (port_grant_o & ~$past(port_req_i)) == 4'h0)
        else $error("grant to idle port");
    a_credit_pulse: assert property (fc_update_i |=> fc_valid_o) else $error("no credit release");
    a_credit_quiet: assert property (!fc_update_i |=> !fc_valid_o) else $error("stray release");
    a_credit_step: assert property (fc_update_i && fc_avail_i >= 8'h02 |=> fc_release_o inside {2'h1, 2'h2})
        else $error("bad credit step");
    a_credit_empty: assert property (fc_update_i && fc_avail_i == 8'h00 |=> fc_release_o == 2'h0)
        else $error("credit from empty pool");
    a_tx_single: assert property (tx_start_o |=> !tx_start_o) else $error("tx start too long");
    a_order_steady: assert property (s_quiet_cfg |=> $stable({ord_egress_o, ord_cpl_tag_o}))
        else $error("ordering moved");
endmodule // sfmc_switch_mode_sva

// file: sfmc_switch_mode_tb.sv
// self-checking bench for the switch forwarding mode bank
// assumes the checker and partner files are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module sfmc_switch_mode_tb;
    logic clk_i = 0, rst_n_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, cfg_dn_i = 0, ld_valid_i = 0, ld_eeprom_i = 0;
    logic ld_dn_i = 0, rx_start_i = 0, rx_done_i = 0, rx_good_i = 0, slow_to_fast_i = 0, arb_adv_i = 0;
    logic fc_update_i = 0, cfg_rvalid_o, tx_start_o, fc_valid_o, ord_egress_o, ord_cpl_tag_o;
    logic [7:0] cfg_addr_i = 0, ld_addr_i = 0, fc_add = 0, fc_avail_i;
    logic [3:0] cfg_be_i = 0, port_req_i = 0, port_credit_ok_i = 0, port_grant_o;
    logic [31:0] cfg_wdata_i = 0, ld_data_i = 0, cfg_rdata_o, e1;
    logic [4:0] strap_low_drive_current_i = 0, up_drive_amp_o, dn_drive_amp_o;
    logic [9:0] pkt_len_i = 0;
    logic [1:0] fc_release_o, e2;
    logic [6:0] r7;
    logic [31:0] rq[$];
    logic [1:0] fq[$];
    int mismatches = 0, total_checks = 0, cyc = 0, lat;
    sfmc_switch_mode u_sfmc_switch_mode (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_dn_i(cfg_dn_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .ld_valid_i(ld_valid_i), .ld_eeprom_i(ld_eeprom_i),
        .ld_dn_i(ld_dn_i), .ld_addr_i(ld_addr_i), .ld_data_i(ld_data_i),
        .strap_low_drive_current_i(strap_low_drive_current_i), .up_drive_amp_o(up_drive_amp_o),
        .dn_drive_amp_o(dn_drive_amp_o), .rx_start_i(rx_start_i), .rx_done_i(rx_done_i), .rx_good_i(rx_good_i),
        .pkt_len_i(pkt_len_i), .slow_to_fast_i(slow_to_fast_i), .tx_start_o(tx_start_o), .arb_adv_i(arb_adv_i),
        .port_req_i(port_req_i), .port_credit_ok_i(port_credit_ok_i), .port_grant_o(port_grant_o),
        .fc_update_i(fc_update_i), .fc_avail_i(fc_avail_i), .fc_release_o(fc_release_o), .fc_valid_o(fc_valid_o),
        .ord_egress_o(ord_egress_o), .ord_cpl_tag_o(ord_cpl_tag_o));
    sfmc_link_partner u_sfmc_link_partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .add_i(fc_add),
        .fc_valid_i(fc_valid_o), .fc_release_i(fc_release_o), .fc_avail_o(fc_avail_i));
    // clock and hang guard
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            final_report;
        end
    end
    // result watcher takes the oldest note per answer
    always @(negedge clk_i)
    begin
        if (cfg_rvalid_o === 1'b1)
        begin
            e1 = rq.pop_front();
            `CHK("cfg_rdata", e1, cfg_rdata_o)
        end
        if (fc_valid_o === 1'b1)
        begin
            e2 = fq.pop_front();
            `CHK("fc_release", e2, fc_release_o)
        end
    end
    task step;
        @(posedge clk_i);
        #1;
    endtask
    task wr(input dn, input [7:0] a, input [3:0] be, input [31:0] v);
        step;
        {cfg_wr_i, cfg_dn_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {1'b1, dn, a, be, v};
        step;
        cfg_wr_i = 0;
    endtask
    task rd(input dn, input [7:0] a, input [31:0] e);
        step;
        {cfg_rd_i, cfg_dn_i, cfg_addr_i} = {1'b1, dn, a};
        rq.push_back(e);
        step;
        cfg_rd_i = 0;
    endtask
    task ld(input ee, input dn, input [31:0] v);
        step;
        {ld_valid_i, ld_eeprom_i, ld_dn_i, ld_addr_i, ld_data_i} = {1'b1, ee, dn, 8'hb4, v};
        step;
        ld_valid_i = 0;
    endtask
    task mode(input [6:0] m);
        wr(0, 8'hb4, 4'h1, {25'h0, m});
    endtask
    task fc(input [1:0] e);
        step;
        fc_update_i = 1;
        fq.push_back(e);
        step;
        fc_update_i = 0;
    endtask
    task adv(input [3:0] r, input [3:0] c, input [3:0] e);
        step;
        {port_req_i, port_credit_ok_i, arb_adv_i} = {r, c, 1'b1};
        step;
        arb_adv_i = 0;
        `CHK("port_grant", e, port_grant_o)
    endtask
    // one packet; lat counts cycles until egress starts, 60 means never
    task pkt(input s2f, input done, input good);
        step;
        {rx_start_i, pkt_len_i, slow_to_fast_i} = {1'b1, 10'd20, s2f};
        step;
        rx_start_i = 0;
        lat = 0;
        if (done)
        begin
            {rx_done_i, rx_good_i} = {1'b1, good};
            step;
            rx_done_i = 0;
        end
        while (tx_start_o !== 1'b1 && lat < 60)
        begin
            step;
            lat++;
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        void'($urandom(32'h1ca48968));
        strap_low_drive_current_i = 5'($urandom);
        repeat (3) @(posedge clk_i);
        #1 rst_n_i = 1;
        rd(0, 8'hb4, 32'h21b7_0002);
        rd(1, 8'hb4, 32'h21a0_0000 | {11'h0, strap_low_drive_current_i, 16'h0});
        rd(0, 8'hb8, 32'h0000_4030);
        rd(1, 8'h10, 32'h0000_0000);
        `CHK("up_drive", 5'b10111, up_drive_amp_o)
        `CHK("dn_drive", strap_low_drive_current_i, dn_drive_amp_o)
        $display("test reset done");
        r7 = 7'($urandom);
        mode(r7);
        rd(0, 8'hb4, 32'h21b7_0000 | r7);
        wr(0, 8'hb4, 4'hf, 32'hffff_ffff);
        wr(0, 8'hb8, 4'hf, 32'hffff_ffff);
        rd(0, 8'hb4, 32'h21b7_3f7f);
        rd(0, 8'hb8, 32'h0000_4030);
        `CHK("ord_bits", 2'b11, {ord_egress_o, ord_cpl_tag_o})
        wr(1, 8'hb4, 4'hf, 32'hffff_ffff);
        rd(1, 8'hb4, 32'h21a0_ff00 | {11'h0, strap_low_drive_current_i, 16'h0});
        $display("test write done");
        ld(0, 0, 32'h0011_0055);
        rd(0, 8'hb4, 32'h21b1_0055);
        `CHK("up_drive", 5'h11, up_drive_amp_o)
        ld(1, 0, 32'h0008_0000);
        rd(0, 8'hb4, 32'h21b1_0000);
        ld(1, 1, 32'h0005_0000);
        step;
        `CHK("dn_drive", 5'h05, dn_drive_amp_o)
        $display("test load done");
        step;
        fc_add = 8'h05;
        step;
        fc_add = 8'h00;
        fc(2'h2);
        mode(7'h10);
        fc(2'h1);
        mode(7'h00);
        fc(2'h2);
        fc(2'h0);
        $display("test credit done");
        adv(4'h3, 4'h2, 4'h2);
        adv(4'h3, 4'h1, 4'h1);
        mode(7'h08);
        adv(4'h3, 4'h2, 4'h1);
        mode(7'h00);
        adv(4'h3, 4'h2, 4'h2);
        $display("test arbiter done");
        for (int t = 0; t < 4; t++)
        begin
            mode({4'h0, t[1:0], 1'b0});
            pkt(1, 0, 0);
            `CHK("ct_latency", 11 - t, lat)
        end
        pkt(0, 0, 0);
        `CHK("ct_latency", 11, lat)
        mode(7'h01);
        pkt(1, 1, 1);
        `CHK("sf_latency", 0, lat)
        pkt(1, 1, 0);
        `CHK("sf_latency", 60, lat)
        $display("test forwarding done");
        final_report;
    end
endmodule // sfmc_switch_mode_tb
bind sfmc_switch_mode sfmc_switch_mode_sva u_sfmc_switch_mode_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .ld_valid_i(ld_valid_i), .cfg_rvalid_o(cfg_rvalid_o),
    .arb_adv_i(arb_adv_i), .port_req_i(port_req_i), .port_grant_o(port_grant_o), .fc_update_i(fc_update_i),
    .fc_avail_i(fc_avail_i), .fc_valid_o(fc_valid_o), .fc_release_o(fc_release_o), .tx_start_o(tx_start_o),
    .ord_egress_o(ord_egress_o), .ord_cpl_tag_o(ord_cpl_tag_o));
